// *** core/asc_pkg.sv ***
// Package with register map, field positions and codes of the sequence control.
package asc_pkg;
   // ==========================================================
   // Register offsets
   localparam logic [7:0] ASC_OFF_FLAGS = 8'h00;
   localparam logic [7:0] ASC_OFF_CTL0 = 8'h04;
   localparam logic [7:0] ASC_OFF_CTL1 = 8'h08;
   localparam logic [7:0] ASC_OFF_SPT_HI = 8'h0C;
   localparam logic [7:0] ASC_OFF_SPT_LO = 8'h10;
   localparam logic [7:0] ASC_OFF_WDH = 8'h24;
   localparam logic [7:0] ASC_OFF_WDL = 8'h28;
   // ==========================================================
   // Reset values
   localparam logic [31:0] ASC_RST_ZERO = 32'h0000_0000;
   localparam logic [11:0] ASC_RST_WDH = 12'hFFF;
   // ==========================================================
   // Flag register bits
   localparam int ASC_B_WDE = 0;
   localparam int ASC_B_DONE = 1;
   localparam int ASC_B_START = 4;
   // ==========================================================
   // First control register bits
   localparam int ASC_B_WCH = 0;
   localparam int ASC_B_DONEIE = 5;
   localparam int ASC_B_WINDOW_IRQ_ENABLE = 6;
   localparam int ASC_B_SCAN = 8;
   localparam int ASC_B_SINGLE = 9;
   localparam int ASC_B_BURST = 11;
   localparam int ASC_B_BCNT = 13;
   localparam int ASC_B_MODE = 16;
   localparam int ASC_B_ROUTINE_WINDOW_ENABLE = 23;
   localparam logic [31:0] ASC_CTL0_MASK = 32'h008F_EB7F;
   // ==========================================================
   // Second control register bits
   localparam int ASC_B_ON = 0;
   localparam int ASC_B_REPEAT = 1;
   localparam int ASC_B_CAL = 2;
   localparam int ASC_B_CALRST = 3;
   localparam int ASC_B_DMA = 8;
   localparam int ASC_B_ALIGN = 11;
   localparam int ASC_B_TSEL = 17;
   localparam int ASC_B_TEN = 20;
   localparam int ASC_B_SWST = 22;
   localparam int ASC_B_INTEN = 23;
   localparam logic [31:0] ASC_CTL1_MASK = 32'h00DE_090F;
   localparam logic [31:0] ASC_SPT_HI_MASK = 32'h00FF_FFFF;
   localparam logic [31:0] ASC_SPT_LO_MASK = 32'h3FFF_FFFF;
   // ==========================================================
   // Codes
   localparam logic [2:0] ASC_TSEL_SW = 3'h7;
   localparam logic [4:0] ASC_CH_MAX = 5'h11;
   localparam logic [4:0] ASC_CH_INT0 = 5'h10;
   localparam int ASC_NCH = 18;
   typedef enum logic [1:0] {
      ASC_MODE_FREE, ASC_MODE_PAR, ASC_MODE_FAST, ASC_MODE_SLOW
   } asc_mode_t;
   localparam logic [3:0] ASC_SM_FREE = 4'h0;
   localparam logic [3:0] ASC_SM_PAR = 4'h6;
   localparam logic [3:0] ASC_SM_FAST = 4'h7;
   localparam logic [3:0] ASC_SM_SLOW = 4'h8;
   // Sample times in half converter-clock cycles (1.5 -> 3).
   localparam logic [8:0] ASC_SPT_HALF [8] = '{9'd3, 9'd15, 9'd27,
      9'd57, 9'd83, 9'd111, 9'd143, 9'd479};
endpackage

// *** core/asc_sync2.sv ***
// Two-flop synchroniser bank for trigger pins.
`timescale 1ns/10ps
module asc_sync2 #(
   parameter int W = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;
   // ==========================================================
   // Only the second stage may be read.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_r <= '0;
         q <= '0;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule

// *** core/asc_ctrl.sv ***
// Routine sequence control and status registers of a converter.
`timescale 1ns/10ps
// What this block does
// - Start flag sets when a routine sequence begins; software writing 0 clears.
// - Done flag sets at sequence end; cleared by writing 0 or data read.
// - Window event flag sets on out-of-window result; only writing 0 clears.
// - Dual mode field decodes 0000, 0110, 0111, 1000; other codes reserved.
// - Each burst trigger converts burst count plus one channels.
// - Bit 11 selects burst-per-trigger operation, clear selects normal.
// - Single-channel bit limits window checking to the selected channel.
// - Channel select codes 0 to 17 map to channels; above is reserved.
// - Window comparisons happen only while bit 23 enable is set.
// - Interrupt raised for done flag with bit 5, event flag with bit 6.
// - Scan bit steps whole sequence; clear converts one channel.
// - With select 111, writing start bit begins sequence; hardware clears it.
// - Triggers accepted only while trigger enable bit 20 is set.
// - Trigger select picks timer, external line or software start source.
// - DMA enable bit gates data requests; clear issues none.
// - Calibration reset and calibrate bits clear when the core finishes.
// - Repeat bit restarts conversion without further triggers.
// - On rising wakes; rewrite of 1 with no other bit changed starts; writing 0 powers down.
// - Each of 18 channels has a 3-bit sample time code.
// - Watchdog thresholds are 12 bits in bits 11 to 0.
// - Internal channels 16 and 17 usable only with their enable set.
module asc_ctrl (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [31:0] rdata,
   input wire logic [6:0] trig_pins,
   input wire logic core_seq_begin,
   input wire logic core_seq_end,
   input wire logic core_result_vld,
   input wire logic [4:0] core_result_ch,
   input wire logic [11:0] core_result,
   input wire logic core_calrst_done,
   input wire logic core_cal_done,
   input wire logic data_read,
   output logic core_power_on,
   output logic core_wake,
   output logic core_start,
   output logic core_scan,
   output logic core_repeat,
   output logic core_burst,
   output logic [3:0] core_burst_len,
   output logic core_calrst_req,
   output logic core_cal_req,
   output logic core_align_msb,
   output logic core_int_ch_en,
   output asc_pkg::asc_mode_t core_dual_mode,
   output logic core_mode_bad,
   output logic [8:0] core_spt_half,
   output logic dma_req,
   output logic irq
);
   import asc_pkg::*;

   logic [31:0] ctl0_r;
   logic [31:0] ctl1_r;
   logic [31:0] spt_hi_r;
   logic [31:0] spt_lo_r;
   logic [11:0] wdh_r;
   logic [11:0] wdl_r;
   logic start_flag_r;
   logic done_flag_r;
   logic wde_flag_r;
   logic [6:0] pins_s;
   logic [6:0] pins_d_r;
   logic [7:0] srcs;
   logic trig_rise;
   logic sw_go;
   logic on_again;
   logic seq_go;
   logic hit_ok;
   logic out_win;
   logic [2:0] spt_code;
   logic [2:0] spt_codes [ASC_NCH];
   logic wr_flags;
   logic wr_ctl1;

   assign wr_flags = wr_en && (addr == ASC_OFF_FLAGS);
   assign wr_ctl1 = wr_en && (addr == ASC_OFF_CTL1);

   // ==========================================================
   // Trigger sources
   asc_sync2 #(.W(7)) u_sync (
      .clk(clk),
      .rst(rst),
      .d(trig_pins),
      .q(pins_s)
   );

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pins_d_r <= '0;
      end else begin
         pins_d_r <= pins_s;
      end
   end

   // Source 7 is tied low (software start goes through sw_go); other sources are rising pin edges.
   assign srcs = {1'b0, pins_s & ~pins_d_r};
   assign trig_rise = srcs[ctl1_r[ASC_B_TSEL +: 3]];
   assign sw_go = ctl1_r[ASC_B_SWST] &&
      (ctl1_r[ASC_B_TSEL +: 3] == ASC_TSEL_SW);
   assign on_again = wr_ctl1 && ctl1_r[ASC_B_ON] &&
      (wdata[31:0] & ASC_CTL1_MASK) == ctl1_r;
   assign seq_go = (ctl1_r[ASC_B_TEN] && (trig_rise || sw_go))
      || on_again;

   // ==========================================================
   // Control registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctl0_r <= ASC_RST_ZERO;
      end else if (wr_en && addr == ASC_OFF_CTL0) begin
         ctl0_r <= wdata & ASC_CTL0_MASK;
      end
   end

   // Hardware clear of handshake bits wins over a software set in that cycle
   // only for the software start bit, which must not restart the sequence.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctl1_r <= ASC_RST_ZERO;
      end else begin
         if (wr_ctl1) begin
            ctl1_r <= wdata & ASC_CTL1_MASK;
         end
         if (sw_go && ctl1_r[ASC_B_TEN]) begin
            ctl1_r[ASC_B_SWST] <= 1'b0;
         end
         if (core_calrst_done && !(wr_ctl1 && wdata[ASC_B_CALRST])) begin
            ctl1_r[ASC_B_CALRST] <= 1'b0;
         end
         if (core_cal_done && !(wr_ctl1 && wdata[ASC_B_CAL])) begin
            ctl1_r[ASC_B_CAL] <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         spt_hi_r <= ASC_RST_ZERO;
      end else if (wr_en && addr == ASC_OFF_SPT_HI) begin
         spt_hi_r <= wdata & ASC_SPT_HI_MASK;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         spt_lo_r <= ASC_RST_ZERO;
      end else if (wr_en && addr == ASC_OFF_SPT_LO) begin
         spt_lo_r <= wdata & ASC_SPT_LO_MASK;
      end
   end

   // Only the low twelve bits are kept; the upper bits of a write are lost.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wdh_r <= ASC_RST_WDH;
      end else if (wr_en && addr == ASC_OFF_WDH) begin
         wdh_r <= wdata[11:0];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wdl_r <= ASC_RST_ZERO[11:0];
      end else if (wr_en && addr == ASC_OFF_WDL) begin
         wdl_r <= wdata[11:0];
      end
   end

   // ==========================================================
   // Window watchdog
   assign hit_ok = ctl0_r[ASC_B_ROUTINE_WINDOW_ENABLE] && core_result_vld &&
      (!ctl0_r[ASC_B_SINGLE] ||
       (core_result_ch == ctl0_r[ASC_B_WCH +: 5] &&
        ctl0_r[ASC_B_WCH +: 5] <= ASC_CH_MAX));
   assign out_win = (core_result > wdh_r) || (core_result < wdl_r);

   // ==========================================================
   // Status flags; a hardware set wins over a clear in the same cycle.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         start_flag_r <= 1'b0;
      end else if (core_seq_begin) begin
         start_flag_r <= 1'b1;
      end else if (wr_flags && !wdata[ASC_B_START]) begin
         start_flag_r <= 1'b0;
      end
   end

   // Reading the routine data clears the done flag as well.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         done_flag_r <= 1'b0;
      end else if (core_seq_end) begin
         done_flag_r <= 1'b1;
      end else if ((wr_flags && !wdata[ASC_B_DONE]) || data_read) begin
         done_flag_r <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wde_flag_r <= 1'b0;
      end else if (hit_ok && out_win) begin
         wde_flag_r <= 1'b1;
      end else if (wr_flags && !wdata[ASC_B_WDE]) begin
         wde_flag_r <= 1'b0;
      end
   end

   // ==========================================================
   // Per-channel sample time lookup
   genvar gi;
   generate
      for (gi = 0; gi < ASC_NCH; gi++) begin : g_spt
         if (gi < 10) begin : g_lo
            assign spt_codes[gi] = spt_lo_r[3*gi +: 3];
         end else begin : g_hi
            assign spt_codes[gi] = spt_hi_r[3*(gi-10) +: 3];
         end
      end
   endgenerate
   assign spt_code = (core_result_ch <= ASC_CH_MAX) ?
      spt_codes[core_result_ch] : 3'h0;

   // ==========================================================
   // Outputs to the converter core
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         core_power_on <= 1'b0;
         core_wake <= 1'b0;
         core_start <= 1'b0;
      end else begin
         core_power_on <= ctl1_r[ASC_B_ON];
         core_wake <= wr_ctl1 && wdata[ASC_B_ON] && !ctl1_r[ASC_B_ON];
         core_start <= seq_go && ctl1_r[ASC_B_ON];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         core_scan <= 1'b0;
         core_repeat <= 1'b0;
         core_burst <= 1'b0;
         core_burst_len <= 4'h1;
      end else begin
         core_scan <= ctl0_r[ASC_B_SCAN];
         core_repeat <= ctl1_r[ASC_B_REPEAT];
         core_burst <= ctl0_r[ASC_B_BURST];
         core_burst_len <= {1'b0, ctl0_r[ASC_B_BCNT +: 3]} + 4'h1;
      end
   end

   // Requests follow the register bits, so they drop once the core is done.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         core_calrst_req <= 1'b0;
         core_cal_req <= 1'b0;
      end else begin
         core_calrst_req <= ctl1_r[ASC_B_CALRST];
         core_cal_req <= ctl1_r[ASC_B_CAL];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         core_align_msb <= 1'b0;
         core_int_ch_en <= 1'b0;
         core_spt_half <= ASC_SPT_HALF[0];
      end else begin
         core_align_msb <= ctl1_r[ASC_B_ALIGN];
         core_int_ch_en <= ctl1_r[ASC_B_INTEN];
         core_spt_half <= ASC_SPT_HALF[spt_code];
      end
   end

   // Reserved codes fall back to independent operation and are flagged.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         core_dual_mode <= ASC_MODE_FREE;
         core_mode_bad <= 1'b0;
      end else begin
         core_mode_bad <= 1'b0;
         case (ctl0_r[ASC_B_MODE +: 4])
            ASC_SM_FREE: core_dual_mode <= ASC_MODE_FREE;
            ASC_SM_PAR: core_dual_mode <= ASC_MODE_PAR;
            ASC_SM_FAST: core_dual_mode <= ASC_MODE_FAST;
            ASC_SM_SLOW: core_dual_mode <= ASC_MODE_SLOW;
            default: begin
               core_dual_mode <= ASC_MODE_FREE;
               core_mode_bad <= 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dma_req <= 1'b0;
      end else begin
         dma_req <= ctl1_r[ASC_B_DMA] && core_seq_end;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= (done_flag_r && ctl0_r[ASC_B_DONEIE]) ||
            (wde_flag_r && ctl0_r[ASC_B_WINDOW_IRQ_ENABLE]);
      end
   end

   // ==========================================================
   // Register read port; unmapped addresses read zero.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata <= ASC_RST_ZERO;
      end else if (rd_en) begin
         case (addr)
            ASC_OFF_FLAGS: rdata <= {27'h0, start_flag_r, 2'h0,
               done_flag_r, wde_flag_r};
            ASC_OFF_CTL0: rdata <= ctl0_r;
            ASC_OFF_CTL1: rdata <= ctl1_r;
            ASC_OFF_SPT_HI: rdata <= spt_hi_r;
            ASC_OFF_SPT_LO: rdata <= spt_lo_r;
            ASC_OFF_WDH: rdata <= {20'h0, wdh_r};
            ASC_OFF_WDL: rdata <= {20'h0, wdl_r};
            default: rdata <= ASC_RST_ZERO;
         endcase
      end else begin
         rdata <= ASC_RST_ZERO;
      end
   end
endmodule

// *** testbench/asc_ctrl_properties.sv ***
// Port checks of the sequence control block.
`timescale 1ns/10ps
module asc_ctrl_chk
   import asc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr_en,
   input wire logic core_seq_end,
   input wire logic core_power_on,
   input wire logic core_wake,
   input wire logic core_scan,
   input wire logic core_repeat,
   input wire logic core_burst,
   input wire logic [3:0] core_burst_len,
   input wire logic core_int_ch_en,
   input wire logic core_mode_bad,
   input wire logic dma_req
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // ======
   // A control write followed by two quiet cycles.
   sequence ctl0_wr_s;
      wr_en && addr == ASC_OFF_CTL0 ##1 !wr_en [*2];
   endsequence
   sequence ctl1_wr_s;
      wr_en && addr == ASC_OFF_CTL1 ##1 !wr_en [*2];
   endsequence
   wake_cause_a: assert property (core_wake |-> $past(wr_en &&
      addr == ASC_OFF_CTL1 && wdata[ASC_B_ON])) else $error("bad wake");
   wake_power_a: assert property (core_wake |=> core_power_on)
      else $error("no power after wake");
   power_off_a: assert property (wr_en && addr == ASC_OFF_CTL1 &&
      !wdata[ASC_B_ON] |-> ##2 !core_power_on) else $error("still on");
   burst_len_a: assert property (ctl0_wr_s |-> core_burst_len ==
      {1'h0, $past(wdata[15:13], 2)} + 4'h1) else $error("burst length");
   burst_mode_a: assert property (ctl0_wr_s |-> core_burst ==
      $past(wdata[ASC_B_BURST], 2)) else $error("burst mode");
   scan_mode_a: assert property (ctl0_wr_s |-> core_scan ==
      $past(wdata[ASC_B_SCAN], 2)) else $error("scan mode");
   mode_code_a: assert property (ctl0_wr_s |-> core_mode_bad ==
      !($past(wdata[19:16], 2) inside {4'h0, 4'h6, 4'h7, 4'h8}))
      else $error("mode code");
   repeat_mode_a: assert property (ctl1_wr_s |-> core_repeat ==
      $past(wdata[ASC_B_REPEAT], 2)) else $error("repeat mode");
   int_chan_a: assert property (ctl1_wr_s |-> core_int_ch_en ==
      $past(wdata[ASC_B_INTEN], 2)) else $error("internal channels");
   dma_gate_a: assert property (dma_req |-> $past(core_seq_end))
      else $error("stray dma request");
endmodule
bind asc_ctrl asc_ctrl_chk i_chk (.clk, .rst, .addr, .wdata, .wr_en,
   .core_seq_end, .core_power_on, .core_wake, .core_scan, .core_repeat,
   .core_burst, .core_burst_len, .core_int_ch_en, .core_mode_bad, .dma_req);

// *** testbench/asc_core_model.sv ***
// Behavioural analog core answering starts and calibration requests.
`timescale 1ns/10ps
module asc_core_model #(
   parameter int CAL_WAIT = 3
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic core_start,
   input wire logic core_calrst_req,
   input wire logic core_cal_req,
   input wire logic [11:0] res_val,
   output logic core_seq_begin,
   output logic core_result_vld,
   output logic core_seq_end,
   output logic [11:0] core_result,
   output logic core_calrst_done,
   output logic core_cal_done
);
   logic [2:0] seq_r;
   logic [3:0] crs_r;
   logic [3:0] cal_r;
   // ======
   // One channel per start: begin, result and end on successive cycles.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) seq_r <= '0;
      else seq_r <= {seq_r[1:0], core_start};
   end
   assign core_seq_begin = seq_r[0];
   assign core_result_vld = seq_r[1];
   assign core_seq_end = seq_r[2];
   // Outside the valid cycle the bus shows the inverse, never a held value.
   assign core_result = seq_r[1] ? res_val : ~res_val;
   // ======
   // Counters saturate, so each request is answered exactly once.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         crs_r <= '0;
         cal_r <= '0;
      end else begin
         crs_r <= core_calrst_req ? crs_r + {3'h0, crs_r != 4'hF} : 4'h0;
         cal_r <= core_cal_req ? cal_r + {3'h0, cal_r != 4'hF} : 4'h0;
      end
   end
   assign core_calrst_done = crs_r == 4'(CAL_WAIT);
   assign core_cal_done = cal_r == 4'(CAL_WAIT);
endmodule

// *** testbench/testbench.sv ***
// Self-checking bench of the sequence control registers.
`timescale 1ns/10ps
module testbench;
   import asc_pkg::*;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic [7:0] addr = '0;
   logic [31:0] wdata = '0;
   logic wr_en = 1'h0;
   logic rd_en = 1'h0;
   logic [6:0] trig_pins = '0;
   logic data_read = 1'h0;
   logic [4:0] core_result_ch = '0;
   logic [11:0] res_val = '0;
   logic [31:0] rdata;
   logic [11:0] core_result;
   logic [3:0] core_burst_len;
   logic [8:0] core_spt_half;
   logic core_seq_begin, core_seq_end, core_result_vld, core_calrst_done;
   logic core_cal_done, core_power_on, core_wake, core_start, core_scan;
   logic core_repeat, core_burst, core_calrst_req, core_cal_req;
   logic core_align_msb, core_int_ch_en, core_mode_bad, dma_req, irq;
   asc_mode_t core_dual_mode;
   int n_mismatch = 0;
   int checks = 0;
   int n_start = 0;
   logic dma_seen = 1'h0;
   always #2 clk = ~clk;
   always @(posedge clk) begin
      if (core_start) n_start <= n_start + 1;
      if (dma_req) dma_seen <= 1'h1;
   end
   asc_ctrl i_dut (.clk, .rst, .addr, .wdata, .wr_en, .rd_en, .rdata,
      .trig_pins, .core_seq_begin, .core_seq_end, .core_result_vld,
      .core_result_ch, .core_result, .core_calrst_done, .core_cal_done,
      .data_read, .core_power_on, .core_wake, .core_start, .core_scan,
      .core_repeat, .core_burst, .core_burst_len, .core_calrst_req,
      .core_cal_req, .core_align_msb, .core_int_ch_en, .core_dual_mode,
      .core_mode_bad, .core_spt_half, .dma_req, .irq);
   asc_core_model i_core (.clk, .rst, .core_start, .core_calrst_req,
      .core_cal_req, .res_val, .core_seq_begin, .core_result_vld,
      .core_seq_end, .core_result, .core_calrst_done, .core_cal_done);
   // ======
   // Bus cycles and comparison.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: %h not %h", $time, got, exp);
      end
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wr_en <= 1'h1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr_en <= 1'h0;
   endtask
   task automatic rdck(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      rd_en <= 1'h1;
      addr <= a;
      @(posedge clk);
      rd_en <= 1'h0;
      #1 chk(rdata, e);
   endtask
   // Software start of one channel; waits for the end with a bound.
   task automatic conv(input logic [4:0] ch, input logic [11:0] v,
      input logic dma);
      int i;
      @(posedge clk);
      core_result_ch <= ch;
      res_val <= v;
      wr(ASC_OFF_CTL1, 32'h005E_0001 | {23'h0, dma, 8'h0});
      for (i = 0; i < 30 && core_seq_end !== 1'h1; i++) cyc(1);
      if (i == 30) begin
         $display("wrong value at %0t: no sequence end", $time);
         n_mismatch++;
         summarize();
      end
   endtask
   task automatic pulse(input int p, input int e);
      int n0;
      n0 = n_start;
      @(posedge clk);
      trig_pins[p] <= 1'h1;
      repeat (6) @(posedge clk);
      trig_pins[p] <= 1'h0;
      cyc(6);
      chk(n_start - n0, e);
   endtask
   // ======
   // Scenarios.
   task automatic t_regs;
      logic [7:0] o [5];
      logic [31:0] m [5];
      o = '{ASC_OFF_SPT_HI, ASC_OFF_SPT_LO, ASC_OFF_WDH, ASC_OFF_WDL,
         ASC_OFF_CTL0};
      m = '{ASC_SPT_HI_MASK, ASC_SPT_LO_MASK, 32'hFFF, 32'hFFF,
         ASC_CTL0_MASK};
      for (int i = 0; i < 5; i++) rdck(o[i], i == 2 ? 32'hFFF : '0);
      rdck(ASC_OFF_FLAGS, '0);
      for (int i = 0; i < 5; i++) wr(o[i], '1);
      wr(8'h14, '1);
      for (int i = 0; i < 5; i++) rdck(o[i], m[i]);
      rdck(8'h14, '0);
      wr(ASC_OFF_CTL0, '0);
      wr(ASC_OFF_WDH, 32'h800);
      wr(ASC_OFF_WDL, 32'h100);
      $display("register test over");
   endtask
   task automatic t_mode;
      logic [3:0] c;
      for (int i = 0; i < 16; i++) begin
         c = 4'(i);
         wr(ASC_OFF_CTL0, '0);
         wr(ASC_OFF_CTL0, {12'h0, c, c[2:0], 1'h0, c[1], 2'h0, c[0], 8'h0});
         cyc(2);
         chk(core_dual_mode, c == 4'h6 ? ASC_MODE_PAR : c == 4'h7 ?
            ASC_MODE_FAST : c == 4'h8 ? ASC_MODE_SLOW : ASC_MODE_FREE);
         chk(core_mode_bad, !(c inside {4'h0, 4'h6, 4'h7, 4'h8}));
         chk(core_burst_len, c[2:0] + 4'h1);
         chk(core_scan, c[0]);
         chk(core_burst, c[1]);
      end
      wr(ASC_OFF_CTL0, '0);
      $display("mode test over");
   endtask
   task automatic t_spt;
      int k;
      wr(ASC_OFF_SPT_LO, 32'h00FA_C688);
      wr(ASC_OFF_SPT_HI, 32'h0005_3977);
      for (int ch = 0; ch < 18; ch++) begin
         k = ch < 8 ? ch : ch < 10 ? 0 : 17 - ch;
         @(posedge clk);
         core_result_ch <= 5'(ch);
         cyc(3);
         chk(core_spt_half, ASC_SPT_HALF[k]);
      end
      $display("sample time test over");
   endtask
   task automatic t_seq;
      wr(ASC_OFF_CTL0, 32'h20);
      wr(ASC_OFF_CTL1, 32'h1);
      conv(5'h0, 12'h400, 1'h1);
      cyc(2);
      chk(irq, 1'h1);
      chk(dma_seen, 1'h1);
      rdck(ASC_OFF_FLAGS, 32'h12);
      rdck(ASC_OFF_CTL1, 32'h001E_0101);
      wr(ASC_OFF_FLAGS, '1);
      rdck(ASC_OFF_FLAGS, 32'h12);
      @(posedge clk);
      data_read <= 1'h1;
      @(posedge clk);
      data_read <= 1'h0;
      rdck(ASC_OFF_FLAGS, 32'h10);
      wr(ASC_OFF_FLAGS, '0);
      rdck(ASC_OFF_FLAGS, '0);
      cyc(2);
      chk(irq, 1'h0);
      $display("sequence test over");
   endtask
   task automatic t_wd;
      logic [31:0] c [6];
      logic [4:0] h [6];
      logic [11:0] v [6];
      logic [5:0] e;
      c = '{32'h80_0000, 32'h80_0000, 0, 32'h80_0205, 32'h80_0205,
         32'h80_0212};
      h = '{5'h3, 5'h3, 5'h3, 5'h3, 5'h5, 5'h12};
      v = '{12'h900, 12'h7FF, 12'h900, 12'h900, 12'h0FF, 12'h900};
      e = 6'b010001;
      dma_seen <= 1'h0;
      for (int i = 0; i < 6; i++) begin
         wr(ASC_OFF_CTL0, c[i] | 32'h40);
         conv(h[i], v[i], 1'h0);
         cyc(2);
         chk(irq, e[i]);
         rdck(ASC_OFF_FLAGS, {31'h9, e[i]});
         wr(ASC_OFF_FLAGS, '0);
      end
      chk(dma_seen, 1'h0);
      $display("watchdog test over");
   endtask
   task automatic t_trig;
      for (int s = 0; s < 7; s++) begin
         wr(ASC_OFF_CTL1, 32'h0010_0001 | 32'(s) << 17);
         pulse(s == 0 ? 6 : s - 1, 0);
         pulse(s, 1);
      end
      wr(ASC_OFF_CTL1, 32'h1);
      pulse(0, 0);
      $display("trigger test over");
   endtask
   task automatic t_power;
      int n0;
      n0 = n_start;
      wr(ASC_OFF_CTL1, 32'h1);
      cyc(4);
      chk(n_start - n0, 1);
      wr(ASC_OFF_CTL1, 32'h0080_0803);
      cyc(2);
      chk({core_repeat, core_int_ch_en}, 2'h3);
      chk({core_power_on, core_align_msb}, 2'h3);
      wr(ASC_OFF_CTL1, 32'h0);
      cyc(2);
      chk(core_power_on, 1'h0);
      wr(ASC_OFF_CTL1, 32'h1);
      for (int b = 2; b < 4; b++) begin
         wr(ASC_OFF_CTL1, 32'h1 | 32'h1 << b);
         cyc(1);
         chk(b == 3 ? core_calrst_req : core_cal_req, 1'h1);
         cyc(8);
         rdck(ASC_OFF_CTL1, 32'h1);
      end
      $display("power test over");
   endtask
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'h0;
      t_regs();
      t_mode();
      t_spt();
      t_seq();
      t_wd();
      t_trig();
      t_power();
      summarize();
   end
endmodule
